// >>> hdl/osc_ctrl_pkg.sv
package osc_ctrl_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  status_offset   = 8'h0c;
   localparam logic [7:0]  control_offset  = 8'h10;
   localparam logic [15:0] control_reset   = 16'h0080;
   // writable bits of the control word; 5:3 and 0 read as zero
   localparam logic [15:0] control_mask    = 16'hffc6;

   // ----------------------------------------------------------------
   // control field positions
   // ----------------------------------------------------------------
   localparam int count_select_a_lsb   = 12;
   localparam int autogain_bit  = 11;
   localparam int gain_lsb      = 8;
   localparam int on_request_bit = 7;
   localparam int standby_bit   = 6;
   localparam int pad_sel_bit   = 2;
   localparam int enable_bit    = 1;

   // ----------------------------------------------------------------
   // status field positions
   // ----------------------------------------------------------------
   localparam int st_sync_busy_bit   = 11;
   localparam int st_detect_bit      = 10;
   localparam int st_mon_ready_bit   = 9;
   localparam int st_ref_stop_bit    = 8;
   localparam int st_coarse_bit      = 7;
   localparam int st_fine_bit        = 6;
   localparam int st_oob_bit         = 5;
   localparam int st_fll_sync_bit    = 4;
   localparam int st_8m_bit          = 3;
   localparam int st_32k_bit         = 2;
   localparam int st_x32k_bit        = 1;
   localparam int st_crystal_osc_control_bit        = 0;

   // ----------------------------------------------------------------
   // timing and codes
   // ----------------------------------------------------------------
   localparam logic [1:0]  sync_cycles      = 2'h3;
   localparam logic [2:0]  gain_max_code    = 3'h4;
   localparam logic [2:0]  gain_reset       = 3'h0;
   localparam logic [1:0]  resp_okay        = 2'h0;
   localparam logic [1:0]  resp_decerr      = 2'h3;

   typedef enum logic [1:0] {
      osc_off   = 2'b00,
      osc_count = 2'b01,
      osc_sync  = 2'b10,
      osc_ready = 2'b11
   } osc_state_e;

   // status levels from the other clock sources and supply monitor
   typedef struct packed {
      logic supply_monitor_sync_busy;
      logic supply_monitor_detect;
      logic supply_monitor_ready;
      logic fll_ref_clock_stopped;
      logic fll_coarse_lock;
      logic fll_fine_lock;
      logic fll_out_of_bounds;
      logic fll_sync_ready;
      logic internal_8m_ready;
      logic internal_32k_ready;
      logic crystal_32k_ready;
   } source_status_s;

   // whole state of the controller
   typedef struct packed {
      logic [15:0] crystal_osc_control;
      logic [2:0]  gain_applied;
      osc_state_e  state;
      logic [15:0] count;
      logic [1:0]  sync_count;
      logic        ulp_prev;
      logic        crystal_osc_control_prev;
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ctrl_state_s;

endpackage

// >>> hdl/crystal_osc_control_control_and_clock_status.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps

// Overview of operation
// - bit 11 shows supply monitor sync busy
// - bit 10 shows supply below reference
// - bit 8 shows loop reference clock stopped
// - bits 7, 6 show coarse, fine lock
// - bit 5 shows loop out of bounds
// - bit 4 one means loop sync complete
// - bits 3..0 show source clocks ready
// - control at 0x10, reset 0x0080, write-protected
// - start-up count is two to field power
// - start-up counter runs on slow 32k clock
// - three crystal cycles before ready sets
// - auto gain adjusts amplitude only when enabled
// - gain codes 0-4 valid, 5-7 reserved
// - gain writes ignored while auto gain active
// - on request: run only while requested
// - on request clear: run whenever enabled
// - standby without keep-running stops oscillator
// - standby with keep-running follows normal mode
// - bit 2 selects crystal or external clock
// - bit 1 enables the oscillator
module crystal_osc_control_control_and_clock_status #(
   parameter int addr_width = 8
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // axi4-lite slave
   input  wire logic [addr_width-1:0]         s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [addr_width-1:0]         s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // system side
   input  wire logic                          write_protect,
   input  wire logic                          standby,
   input  wire logic                          clock_request,
   input  wire logic                          ultra_low_power_32k_osc,
   input  wire logic                          multipurpose_crystal_osc,
   input  wire osc_ctrl_pkg::source_status_s  source_status,
   // oscillator side
   output logic                               osc_run,
   output logic                               crystal_pad_select,
   output logic [2:0]                         osc_gain,
   output logic                               auto_amplitude_gain,
   output logic                               crystal_osc_ready
);

   osc_ctrl_pkg::ctrl_state_s q;
   osc_ctrl_pkg::ctrl_state_s next_q;

   logic        run_wanted;
   logic        ulp_rise;
   logic        crystal_osc_control_rise;
   logic        aw_take;
   logic        w_take;
   logic        aw_have;
   logic        w_have;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic [7:0]  rd_addr;
   logic [31:0] status_word;
   logic [15:0] ctrl_new;

   // ----------------------------------------------------------------
   // bus handshakes: one write and one read under way at a time
   // ----------------------------------------------------------------
   assign s_axi_awready = !q.aw_held && !q.bvalid;
   assign s_axi_wready  = !q.w_held && !q.bvalid;
   assign s_axi_arready = !q.rvalid;
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign aw_have       = q.aw_held || aw_take;
   assign w_have        = q.w_held || w_take;
   assign wr_addr       = q.aw_held ? q.aw_addr : s_axi_awaddr[7:0];
   assign wr_data       = q.w_held ? q.w_data : s_axi_wdata;
   assign wr_strb       = q.w_held ? q.w_strb : s_axi_wstrb;
   assign rd_addr       = s_axi_araddr[7:0];

   // ----------------------------------------------------------------
   // status word, live levels plus our own ready
   // ----------------------------------------------------------------
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[osc_ctrl_pkg::st_sync_busy_bit] =
         source_status.supply_monitor_sync_busy;
      status_word[osc_ctrl_pkg::st_detect_bit] =
         source_status.supply_monitor_detect;
      status_word[osc_ctrl_pkg::st_mon_ready_bit] =
         source_status.supply_monitor_ready;
      status_word[osc_ctrl_pkg::st_ref_stop_bit] =
         source_status.fll_ref_clock_stopped;
      status_word[osc_ctrl_pkg::st_coarse_bit] = source_status.fll_coarse_lock;
      status_word[osc_ctrl_pkg::st_fine_bit]   = source_status.fll_fine_lock;
      status_word[osc_ctrl_pkg::st_oob_bit] = source_status.fll_out_of_bounds;
      // input is high when sync is complete, passed through as is
      status_word[osc_ctrl_pkg::st_fll_sync_bit] = source_status.fll_sync_ready;
      status_word[osc_ctrl_pkg::st_8m_bit]   = source_status.internal_8m_ready;
      status_word[osc_ctrl_pkg::st_32k_bit]  = source_status.internal_32k_ready;
      status_word[osc_ctrl_pkg::st_x32k_bit] = source_status.crystal_32k_ready;
      status_word[osc_ctrl_pkg::st_crystal_osc_control_bit] =
         (q.state == osc_ctrl_pkg::osc_ready);
   end

   // ----------------------------------------------------------------
   // run decision from enable, on-request and standby
   // ----------------------------------------------------------------
   always_comb begin
      run_wanted = q.crystal_osc_control[osc_ctrl_pkg::enable_bit];
      if (q.crystal_osc_control[osc_ctrl_pkg::on_request_bit]) begin
         run_wanted = run_wanted && clock_request;
      end
      // with on-request clear the request line is not looked at
      if (standby) begin
         run_wanted = run_wanted
                      && q.crystal_osc_control[osc_ctrl_pkg::standby_bit];
      end
      // keep-running in standby leaves the normal decision untouched
   end

   // slow and crystal clocks are sampled levels; edges found here
   assign ulp_rise  = ultra_low_power_32k_osc && !q.ulp_prev;
   assign crystal_osc_control_rise = multipurpose_crystal_osc && !q.crystal_osc_control_prev;

   // write data merged by byte lanes, unwritable bits forced low
   always_comb begin
      ctrl_new = q.crystal_osc_control;
      if (wr_strb[0]) begin
         ctrl_new[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
         ctrl_new[15:8] = wr_data[15:8];
      end
      ctrl_new = ctrl_new & osc_ctrl_pkg::control_mask;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_q           = q;
      next_q.ulp_prev  = ultra_low_power_32k_osc;
      next_q.crystal_osc_control_prev = multipurpose_crystal_osc;

      // write channel: address and data taken in either order
      if (aw_take) begin
         next_q.aw_held = 1'b1;
         next_q.aw_addr = s_axi_awaddr[7:0];
      end
      if (w_take) begin
         next_q.w_held = 1'b1;
         next_q.w_data = s_axi_wdata;
         next_q.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         next_q.bvalid = 1'b0;
      end
      if (aw_have && w_have && !q.bvalid) begin
         next_q.aw_held = 1'b0;
         next_q.w_held  = 1'b0;
         next_q.bvalid  = 1'b1;
         next_q.bresp   = osc_ctrl_pkg::resp_okay;
         if (wr_addr == osc_ctrl_pkg::control_offset) begin
            // protected writes are dropped but still answered okay
            if (!write_protect) begin
               next_q.crystal_osc_control = ctrl_new;
            end
         end else if (wr_addr != osc_ctrl_pkg::status_offset) begin
            next_q.bresp = osc_ctrl_pkg::resp_decerr;
         end
      end

      // read channel
      if (q.rvalid && s_axi_rready) begin
         next_q.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !q.rvalid) begin
         next_q.rvalid = 1'b1;
         next_q.rresp  = osc_ctrl_pkg::resp_okay;
         next_q.rdata  = 32'h0000_0000;
         unique case (rd_addr)
            osc_ctrl_pkg::status_offset: begin
               next_q.rdata = status_word;
            end
            osc_ctrl_pkg::control_offset: begin
               next_q.rdata = {16'h0000, q.crystal_osc_control};
            end
            default: begin
               next_q.rresp = osc_ctrl_pkg::resp_decerr;
            end
         endcase
      end

      // gain: frozen while auto gain runs, reserved codes not applied
      if (!q.crystal_osc_control[osc_ctrl_pkg::autogain_bit]
          && q.crystal_osc_control[osc_ctrl_pkg::gain_lsb +: 3]
             <= osc_ctrl_pkg::gain_max_code) begin
         next_q.gain_applied = q.crystal_osc_control[osc_ctrl_pkg::gain_lsb +: 3];
      end

      // start-up sequence
      unique case (q.state)
         osc_ctrl_pkg::osc_off: begin
            if (run_wanted) begin
               next_q.state = osc_ctrl_pkg::osc_count;
               next_q.count = 16'h0001
                  << q.crystal_osc_control[osc_ctrl_pkg::count_select_a_lsb +: 4];
            end
         end
         osc_ctrl_pkg::osc_count: begin
            // counted on the slow clock, not the crystal being started
            if (ulp_rise) begin
               if (q.count == 16'h0001) begin
                  next_q.state      = osc_ctrl_pkg::osc_sync;
                  next_q.sync_count = 2'h0;
               end else begin
                  next_q.count = q.count - 16'h0001;
               end
            end
         end
         osc_ctrl_pkg::osc_sync: begin
            if (crystal_osc_control_rise) begin
               next_q.sync_count = q.sync_count + 2'h1;
               if (q.sync_count + 2'h1 == osc_ctrl_pkg::sync_cycles) begin
                  next_q.state = osc_ctrl_pkg::osc_ready;
               end
            end
         end
         osc_ctrl_pkg::osc_ready: begin
         end
      endcase
      // any stop drops ready; the next start reloads the count
      if (!run_wanted) begin
         next_q.state = osc_ctrl_pkg::osc_off;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q                     <= '0;
         q.crystal_osc_control <= osc_ctrl_pkg::control_reset;
         q.gain_applied        <= osc_ctrl_pkg::gain_reset;
         q.state               <= osc_ctrl_pkg::osc_off;
      end else begin
         q <= next_q;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign s_axi_bvalid       = q.bvalid;
   assign s_axi_bresp        = q.bresp;
   assign s_axi_rvalid       = q.rvalid;
   assign s_axi_rdata        = q.rdata;
   assign s_axi_rresp        = q.rresp;
   // analog run follows the registered state so it never glitches
   assign osc_run            = (q.state != osc_ctrl_pkg::osc_off);
   assign crystal_pad_select = q.crystal_osc_control[osc_ctrl_pkg::pad_sel_bit];
   assign osc_gain           = q.gain_applied;
   // software is trusted to set this only once ready shows
   assign auto_amplitude_gain = q.crystal_osc_control[osc_ctrl_pkg::autogain_bit]
                                && osc_run;
   assign crystal_osc_ready  = (q.state == osc_ctrl_pkg::osc_ready);

endmodule

// >>> verif/osc_chk.sv
`timescale 1ns/1ps

// ------------------------------
// oscillator slice port checks
// ------------------------------
module osc_chk #(
   parameter int addr_width = 8
) (
   input wire logic                         aclk,
   input wire logic                         aresetn,
   input wire logic [addr_width-1:0]        s_axi_araddr,
   input wire logic                         s_axi_arvalid,
   input wire logic                         s_axi_arready,
   input wire logic [31:0]                  s_axi_rdata,
   input wire logic [1:0]                   s_axi_rresp,
   input wire logic                         s_axi_rvalid,
   input wire logic                         multipurpose_crystal_osc,
   input wire osc_ctrl_pkg::source_status_s source_status,
   input wire logic                         osc_run,
   input wire logic [2:0]                   osc_gain,
   input wire logic                         auto_amplitude_gain,
   input wire logic                         crystal_osc_ready
);
   logic       xprev;
   logic [3:0] xedges;

   // crystal edges since the last start; saturates so it cannot wrap
   always_ff @(posedge aclk) begin
      xprev <= multipurpose_crystal_osc;
      if (!aresetn || !osc_run)
         xedges <= 4'h0;
      else if (multipurpose_crystal_osc && !xprev && xedges != 4'hf)
         xedges <= xedges + 4'h1;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_ready_needs_run: assert property (crystal_osc_ready |-> osc_run)
      else $error("ready while stopped");
   chk_count_select_a_sync: assert property ($rose(crystal_osc_ready) |-> xedges >= 4'h3)
      else $error("ready before three crystal edges");
   chk_status_view: assert property (
      $rose(s_axi_rvalid) && $past(s_axi_araddr) == 8'h0c
      |-> s_axi_rdata == {20'h0, $past(source_status), $past(crystal_osc_ready)})
      else $error("status word wrong");
   chk_unmapped_read: assert property (
      $rose(s_axi_rvalid) && !($past(s_axi_araddr) inside {8'h0c, 8'h10})
      |-> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_gain_legal: assert property (osc_gain <= 3'h4)
      else $error("reserved gain applied");
   chk_gain_frozen: assert property (auto_amplitude_gain && $past(auto_amplitude_gain)
      |-> $stable(osc_gain)) else $error("gain moved under auto control");
   chk_auto_gain_run: assert property (auto_amplitude_gain |-> osc_run)
      else $error("auto gain while stopped");

   cover property ($rose(crystal_osc_ready));
   cover property ($fell(osc_run));
   cover property (auto_amplitude_gain);
endmodule

bind crystal_osc_control_control_and_clock_status osc_chk #(.addr_width(addr_width)) i_osc_chk (
   .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .multipurpose_crystal_osc, .source_status, .osc_run, .osc_gain,
   .auto_amplitude_gain, .crystal_osc_ready);

// >>> verif/clock_side_model.sv
`timescale 1ns/1ps

// --------------------------------------------
// requesting peripheral and oscillator sources
// --------------------------------------------
module clock_side_model (
   input  wire logic aclk,
   input  wire logic osc_run,
   input  wire logic want,
   output logic      clock_request = 1'b0,
   output logic      ultra_low_power_32k_osc,
   output logic      multipurpose_crystal_osc = 1'b0
);
   logic [3:0] slow_div = 4'h0;

   // slow source runs free, one sixteenth of the bus clock
   assign ultra_low_power_32k_osc = slow_div[3];

   // request lags its cause by a cycle; crystal rests low when unpowered
   always @(posedge aclk) begin
      slow_div <= slow_div + 4'h1;
      clock_request <= want;
      multipurpose_crystal_osc <= osc_run && !multipurpose_crystal_osc;
   end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps

module testbench;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'd20, v;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, write_protect = 1'b0;
   logic        standby = 1'b0, want = 1'b0, sp, ta, tw;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        clock_request, ultra_low_power_32k_osc, multipurpose_crystal_osc;
   logic        osc_run, crystal_pad_select, auto_amplitude_gain, crystal_osc_ready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  osc_gain, eg;
   logic [33:0] q[$];
   int          err_total = 0, cmp_count = 0, n;
   osc_ctrl_pkg::source_status_s source_status = '0;

   always #25 aclk = ~aclk;

   crystal_osc_control_control_and_clock_status i_crystal_osc_control_control_and_clock_status (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .write_protect, .standby, .clock_request, .ultra_low_power_32k_osc,
      .multipurpose_crystal_osc, .source_status, .osc_run, .crystal_pad_select, .osc_gain,
      .auto_amplitude_gain, .crystal_osc_ready);
   clock_side_model i_clock_side_model (.aclk, .osc_run, .want, .clock_request,
      .ultra_low_power_32k_osc, .multipurpose_crystal_osc);

   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // handshakes judged at the rising edge; each half released once taken there;
   // bready and rready stay high so back-to-back calls never toggle them twice
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      q.push_back({r, 32'h0});
      ta = 1'b0;
      tw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (!ta && s_axi_awready) begin
            ta = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!tw && s_axi_wready) begin
            tw = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!(ta && tw));
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
   endtask

   task automatic wait_ready();
      for (n = 0; n < 300 && crystal_osc_ready !== 1'b1; n++) @(posedge aclk);
   endtask

   // bus answers are matched against the oldest note
   always @(negedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, q.pop_front());
      if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, q.pop_front());
   end

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h10, 34'h80);
      for (int i = 0; i < 11; i++) begin
         source_status <= osc_ctrl_pkg::source_status_s'(11'h1 << i);
         rd(8'h0c, {22'h0, 11'h1 << i, 1'b0});
      end
      source_status <= '0;
      rd(8'h20, {2'h3, 32'h0});
      wr(8'h24, 32'h2, 2'h3);
      wr(8'h0c, 32'hfff, 2'h0);
      write_protect <= 1'b1;
      wr(8'h10, 32'h2, 2'h0);
      write_protect <= 1'b0;
      rd(8'h10, 34'h80);
      $display("register test ended");
      for (int c = 0; c < 4; c++) begin
         wr(8'h10, {16'h0, 4'(c), 12'h002}, 2'h0);
         n = 0;
         sp = ultra_low_power_32k_osc;
         for (int t = 0; t < 900 && crystal_osc_ready !== 1'b1; t++) begin
            @(posedge aclk);
            n += int'(ultra_low_power_32k_osc && !sp);
            sp = ultra_low_power_32k_osc;
         end
         check({33'h0, n >= (1 << c) && n <= (1 << c) + 2}, 34'h1);
         rd(8'h0c, 34'h1);
         wr(8'h10, 32'h0, 2'h0);
         repeat (2) @(posedge aclk);
         check({32'h0, osc_run, crystal_osc_ready}, 34'h0);
      end
      $display("start-up test ended");
      wr(8'h10, 32'h2, 2'h0);
      wait_ready();
      eg = 3'h0;
      // the last pass turns auto gain on, only after the crystal settled
      for (int g = 0; g < 9; g++) begin
         wr(8'h10, {20'h0, g == 8, 3'(g), 8'h02}, 2'h0);
         repeat (2) @(posedge aclk);
         if (g < 5) eg = 3'(g);
         check({31'h0, osc_gain}, {31'h0, eg});
      end
      check({33'h0, auto_amplitude_gain}, 34'h1);
      $display("gain test ended");
      for (int i = 0; i < 40; i++) begin
         v = rnd() & 32'h07c6;
         standby <= seed[16];
         want <= seed[17];
         wr(8'h10, v, 2'h0);
         rd(8'h10, {2'h0, v & osc_ctrl_pkg::control_mask});
         if (v[1] && (!v[7] || seed[17]) && (!seed[16] || v[6])) begin
            wait_ready();
            check({33'h0, crystal_osc_ready}, 34'h1);
         end else begin
            repeat (2) @(posedge aclk);
            check({33'h0, osc_run}, 34'h0);
         end
         check({33'h0, crystal_pad_select}, {33'h0, v[2]});
      end
      $display("mode test ended");
      summarize();
   end

   // cut a hang short
   initial begin
      #2000000;
      err_total++;
      summarize();
   end
endmodule
